// File: hdl/dpr_top.sv
// Data parity error reporting for a two port bus bridge
`timescale 1ns/1ps
// Function
// (RULE1) Primary master parity bit: master on primary, primary enable, error seen
// (RULE2) Primary master bit only upstream read/posted/delayed, primary error, enable
// (RULE3) Secondary master parity bit: master on secondary, secondary enable, error
// (RULE4) Secondary master bit only downstream read/posted/delayed, secondary error
// (RULE5) Primary error pin only as write target or read initiator, enable
// (RULE6) Downstream delayed write completion error on secondary drives primary pin
// (RULE7) Primary pin low: upstream read, downstream posted/delayed write primary
// (RULE8) Secondary error pin only as write target or read initiator, enable
// (RULE9) Upstream delayed write completion error on primary drives secondary pin
// (RULE10) Secondary pin low: downstream read, upstream posted/delayed on secondary
// (RULE11) Error pin driven fixed clocks after data phase, parked high, released
module dpr_top
    import dpr_pkg::*;
(
    input  wire logic           CORE_CLK,
    input  wire logic           NRST,
    input  wire logic [7:0]     WB_ADR_I,
    input  wire logic [31:0]    WB_DAT_I,
    output logic      [31:0]    WB_DAT_O,
    input  wire logic [3:0]     WB_SEL_I,
    input  wire logic           WB_WE_I,
    input  wire logic           WB_CYC_I,
    input  wire logic           WB_STB_I,
    output logic                WB_ACK_O,
    input  wire dpr_pkg::dpr_evt_s EVT_I,
    output logic                PRIM_PERR_N_O,
    output logic                PRIM_PERR_OE,
    output logic                SEC_PERR_N_O,
    output logic                SEC_PERR_OE,
    output logic                IRQ_O
);
    import dpr_pkg::*;

    logic [1:0]            ctrl_reg;
    logic [1:0]            stat_reg;
    logic [DPR_NEVT-1:0]   irq_st_reg;
    logic [DPR_NEVT-1:0]   irq_en_reg;
    logic [DPR_NEVT-1:0]   evt_next;
    logic [DPR_NEVT-1:0]   clr_next;
    logic                  p_en;
    logic                  s_en;
    logic                  rd_up;
    logic                  wr_down;
    logic                  set_pm;
    logic                  set_sm;
    logic                  fire_p;
    logic                  fire_s;
    logic                  wb_req;
    logic                  wb_wr;
    logic                  pend_p_reg;
    logic                  pend_s_reg;
    logic                  done_p;
    logic                  done_s;

    assign p_en   = ctrl_reg[DPR_CTRL_PRESP];
    assign s_en   = ctrl_reg[DPR_CTRL_SRESP];
    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wb_wr  = wb_req && WB_WE_I && WB_SEL_I[0];

    // Upstream read: bridge masters the primary; write downstream: bridge is target on the primary
    assign rd_up   = EVT_I.kind == DPR_READ && EVT_I.upstream;
    assign wr_down = EVT_I.kind != DPR_READ && !EVT_I.upstream;

    // Bridge is primary master for upstream reads and upstream writes
    assign set_pm = EVT_I.valid && EVT_I.upstream && !EVT_I.on_sec
                    && p_en; // see RULE1 see RULE2
    // Bridge is secondary master for downstream transactions
    assign set_sm = EVT_I.valid && !EVT_I.upstream && EVT_I.on_sec
                    && s_en; // see RULE3 see RULE4

    // Primary pin: write target or read initiator on primary (see RULE5)
    always_comb
    begin
        fire_p = 1'b0;
        if (EVT_I.valid && p_en)
        begin
            if (!EVT_I.on_sec && (rd_up || wr_down))
            begin
                fire_p = 1'b1; // see RULE7
            end
            else if (EVT_I.on_sec && EVT_I.kind == DPR_DWR
                     && !EVT_I.upstream && EVT_I.compl_phase
                     && EVT_I.seen_perr && s_en)
            begin
                fire_p = 1'b1; // see RULE6
            end
        end
    end

    // Secondary pin, mirror image of the primary (see RULE8)
    always_comb
    begin
        fire_s = 1'b0;
        if (EVT_I.valid && s_en)
        begin
            if (EVT_I.on_sec && ((EVT_I.kind == DPR_READ
                && !EVT_I.upstream) || (EVT_I.kind != DPR_READ
                && EVT_I.upstream)))
            begin
                fire_s = 1'b1; // see RULE10
            end
            else if (!EVT_I.on_sec && EVT_I.kind == DPR_DWR
                     && EVT_I.upstream && EVT_I.compl_phase
                     && EVT_I.seen_perr && p_en)
            begin
                fire_s = 1'b1; // see RULE9
            end
        end
    end

    assign evt_next = {fire_s, fire_p, set_sm, set_pm};
    assign clr_next = (wb_wr && WB_ADR_I == DPR_IRQCL_OFS)
                      ? WB_DAT_I[DPR_NEVT-1:0] : '0;

    // Master data parity bits are sticky; writing one clears, set wins
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            stat_reg <= '0;
        end
        else
        begin
            // Only the two master bits live here; pin reports go to IRQ
            stat_reg <= (stat_reg & ~((wb_wr && WB_ADR_I == DPR_STAT_OFS)
                        ? WB_DAT_I[1:0] : 2'h0)) | {set_sm, set_pm};
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            irq_st_reg <= '0;
            irq_en_reg <= '0;
            IRQ_O      <= 1'b0;
        end
        else
        begin
            irq_st_reg <= (irq_st_reg & ~clr_next) | evt_next;
            if (wb_wr && WB_ADR_I == DPR_IRQEN_OFS)
            begin
                irq_en_reg <= WB_DAT_I[DPR_NEVT-1:0];
            end
            IRQ_O <= |(irq_st_reg & irq_en_reg);
        end
    end

    // Control register holds both parity error response enables
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ctrl_reg <= DPR_CTRL_RST;
        end
        else if (wb_wr && WB_ADR_I == DPR_CTRL_OFS)
        begin
            ctrl_reg <= WB_DAT_I[1:0];
        end
    end

    // Pending flags show a pin report in flight
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pend_p_reg <= 1'b0;
            pend_s_reg <= 1'b0;
        end
        else
        begin
            pend_p_reg <= fire_p || (pend_p_reg && !done_p);
            pend_s_reg <= fire_s || (pend_s_reg && !done_s);
        end
    end

    // Classic Wishbone slave: registered ack one clock after the strobe, unmapped reads as zero
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end
        else
        begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= '0;
            if (wb_req && !WB_WE_I)
            begin
                if (WB_ADR_I == DPR_CTRL_OFS)
                begin
                    WB_DAT_O <= {30'h0, ctrl_reg};
                end
                else if (WB_ADR_I == DPR_EVT_OFS)
                begin
                    WB_DAT_O <= {30'h0, pend_s_reg, pend_p_reg};
                end
                else if (WB_ADR_I == DPR_STAT_OFS)
                begin
                    WB_DAT_O <= {30'h0, stat_reg};
                end
                else if (WB_ADR_I == DPR_IRQST_OFS)
                begin
                    WB_DAT_O <= {28'h0, irq_st_reg};
                end
                else if (WB_ADR_I == DPR_IRQEN_OFS)
                begin
                    WB_DAT_O <= {28'h0, irq_en_reg};
                end
            end
        end
    end

    dpr_perr_drv u_prim
    (
        .clk      (CORE_CLK),
        .nrst     (NRST),
        .fire     (fire_p),
        .perr_n_o (PRIM_PERR_N_O),
        .perr_oe  (PRIM_PERR_OE),
        .done     (done_p)
    );

    dpr_perr_drv u_sec
    (
        .clk      (CORE_CLK),
        .nrst     (NRST),
        .fire     (fire_s),
        .perr_n_o (SEC_PERR_N_O),
        .perr_oe  (SEC_PERR_OE),
        .done     (done_s)
    );

    a_pm_cause: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $rose(stat_reg[DPR_BIT_PMDPE]) |-> $past(p_en && EVT_I.upstream))
        else $error("primary master bit set without cause"); // see RULE2
    a_sm_cause: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        $rose(stat_reg[DPR_BIT_SMDPE]) |-> $past(s_en && !EVT_I.upstream))
        else $error("secondary master bit set without cause"); // see RULE4
    a_pm_set: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        set_pm |=> stat_reg[DPR_BIT_PMDPE])
        else $error("primary master bit missed"); // see RULE1
    a_sm_set: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        set_sm |=> stat_reg[DPR_BIT_SMDPE])
        else $error("secondary master bit missed"); // see RULE3
    a_p_enable: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        fire_p |-> p_en)
        else $error("primary pin fired while disabled"); // see RULE5
    a_s_enable: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        fire_s |-> s_en)
        else $error("secondary pin fired while disabled"); // see RULE8
    a_p_dwr: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (EVT_I.valid && EVT_I.on_sec && EVT_I.kind == DPR_DWR
         && !EVT_I.upstream && EVT_I.compl_phase && EVT_I.seen_perr
         && p_en && s_en) |=> irq_st_reg[DPR_BIT_PPERR])
        else $error("delayed write error not reported"); // see RULE6
    a_s_dwr: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (EVT_I.valid && !EVT_I.on_sec && EVT_I.kind == DPR_DWR
         && EVT_I.upstream && EVT_I.compl_phase && EVT_I.seen_perr
         && p_en && s_en) |=> irq_st_reg[DPR_BIT_SPERR])
        else $error("delayed write error not reported"); // see RULE9
    a_p_pos: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (EVT_I.valid && p_en && !EVT_I.on_sec && EVT_I.upstream
         && EVT_I.kind == DPR_PWR) |-> !fire_p)
        else $error("primary pin on upstream posted"); // see RULE7
    a_s_pos: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (EVT_I.valid && s_en && EVT_I.on_sec && !EVT_I.upstream
         && EVT_I.kind != DPR_READ) |-> !fire_s)
        else $error("secondary pin on downstream write"); // see RULE10

endmodule : dpr_top

// File: hdl/dpr_pkg.sv
// Package for the bridge data parity reporting block
package dpr_pkg;

    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] DPR_CTRL_OFS  = 8'h00;
    localparam logic [7:0] DPR_EVT_OFS   = 8'h04;
    localparam logic [7:0] DPR_STAT_OFS  = 8'h08;
    localparam logic [7:0] DPR_IRQST_OFS = 8'h0c;
    localparam logic [7:0] DPR_IRQEN_OFS = 8'h10;
    localparam logic [7:0] DPR_IRQCL_OFS = 8'h14;

    // Control fields
    localparam int DPR_CTRL_PRESP = 0;
    localparam int DPR_CTRL_SRESP = 1;
    localparam logic [1:0] DPR_CTRL_RST = 2'h0;

    // Event / status bit positions
    localparam int DPR_BIT_PMDPE = 0;
    localparam int DPR_BIT_SMDPE = 1;
    localparam int DPR_BIT_PPERR = 2;
    localparam int DPR_BIT_SPERR = 3;
    localparam int DPR_NEVT      = 4;

    // Parity error signalling delay after the data phase, in clocks
    localparam logic [1:0] DPR_PERR_DLY = 2'h2;
    localparam logic [1:0] DPR_ONE2     = 2'h1;

    typedef enum logic [1:0]
    {
        DPR_READ  = 2'h0,
        DPR_PWR   = 2'h1,
        DPR_DWR   = 2'h2
    } dpr_kind_e;

    // One reported data phase
    typedef struct packed
    {
        logic      valid;
        dpr_kind_e kind;
        logic      upstream;
        logic      on_sec;
        logic      seen_perr;
        logic      compl_phase;
    } dpr_evt_s;

    typedef enum logic [2:0]
    {
        DPR_IDLE  = 3'b001,
        DPR_DRIVE = 3'b010,
        DPR_PARK  = 3'b100
    } dpr_perr_e;

endpackage : dpr_pkg

// File: hdl/dpr_perr_drv.sv
// One parity error pin driver with delay, drive-low and drive-high park
`timescale 1ns/1ps
module dpr_perr_drv
    import dpr_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic fire,
    output logic      perr_n_o,
    output logic      perr_oe,
    output logic      done
);
    dpr_perr_e  state_reg;
    logic [1:0] cnt_reg;
    logic       armed_reg;

    // Data phase seen: wait the fixed delay, then drive low for one clock,
    // then drive high for one clock before releasing (see RULE11)
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= DPR_IDLE;
            cnt_reg   <= 2'h0;
            armed_reg <= 1'b0;
            perr_n_o  <= 1'b1;
            perr_oe   <= 1'b0;
            done      <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_reg)
                DPR_IDLE:
                begin
                    if (fire && !armed_reg)
                    begin
                        armed_reg <= 1'b1;
                        cnt_reg   <= DPR_PERR_DLY - DPR_ONE2;
                    end
                    else if (armed_reg)
                    begin
                        if (cnt_reg == 2'h0)
                        begin
                            state_reg <= DPR_DRIVE;
                            perr_n_o  <= 1'b0;
                            perr_oe   <= 1'b1;
                            armed_reg <= 1'b0;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg - DPR_ONE2;
                        end
                    end
                end
                DPR_DRIVE:
                begin
                    state_reg <= DPR_PARK;
                    perr_n_o  <= 1'b1;
                    done      <= 1'b1;
                end
                DPR_PARK:
                begin
                    state_reg <= DPR_IDLE;
                    perr_oe   <= 1'b0;
                end
                default:
                begin
                    state_reg <= DPR_IDLE;
                end
            endcase
        end
    end

    a_perr_park: assert property (@(posedge clk) disable iff (!nrst)
        (perr_oe && !perr_n_o) |=> (perr_oe && perr_n_o) ##1 !perr_oe)
        else $error("parity error pin not parked high"); // see RULE11
    a_perr_delay: assert property (@(posedge clk) disable iff (!nrst)
        (fire && state_reg == DPR_IDLE && !armed_reg) |-> ##3 !perr_n_o)
        else $error("parity error not driven after delay"); // see RULE11

endmodule : dpr_perr_drv

// File: bench/dpr_bus_agent.sv
// Far-side bus agent: reports data phases and resolves the error pins
`timescale 1ns/1ps
module dpr_bus_agent
    import dpr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        p_n,
    input  wire logic        p_oe,
    input  wire logic        s_n,
    input  wire logic        s_oe,
    output dpr_pkg::dpr_evt_s evt,
    output logic             p_pin,
    output logic             s_pin
);
    initial evt = '0;

    // Pull-ups own the lines whenever the bridge lets go
    assign p_pin = p_oe ? p_n : 1'b1;
    assign s_pin = s_oe ? s_n : 1'b1;

    // One data phase in error; completion flag only means something for DWR
    task automatic report(input dpr_kind_e k, input logic up, input logic sec);
    begin
        @(posedge clk);
        evt <= '{1'b1, k, up, sec, 1'b1, k == DPR_DWR};
        @(posedge clk);
        evt <= '0;
    end
    endtask : report
endmodule : dpr_bus_agent

// File: bench/test_bridge_data_parity_reporting.sv
// Self-checking bench for the data parity reporting block
`timescale 1ns/1ps
module test_bridge_data_parity_reporting;
    import dpr_pkg::*;
    logic        clk;
    logic        nrst;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
    logic        ack;
    dpr_evt_s    evt;
    logic        p_n;
    logic        p_oe;
    logic        s_n;
    logic        s_oe;
    logic        irq;
    logic        p_pin;
    logic        s_pin;
    logic [3:0]  irq_en;
    int          n_mismatch;
    int          comparisons;

    dpr_top dpr_top_inst (.CORE_CLK(clk), .NRST(nrst), .WB_ADR_I(adr),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_SEL_I(sel), .WB_WE_I(we),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .EVT_I(evt),
        .PRIM_PERR_N_O(p_n), .PRIM_PERR_OE(p_oe), .SEC_PERR_N_O(s_n),
        .SEC_PERR_OE(s_oe), .IRQ_O(irq));
    dpr_bus_agent dpr_bus_agent_inst (.clk(clk), .p_n(p_n), .p_oe(p_oe),
        .s_n(s_n), .s_oe(s_oe), .evt(evt), .p_pin(p_pin), .s_pin(s_pin));

    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
    begin
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask : check

    task automatic complete_run;
    begin
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask : complete_run

    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    begin
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(posedge clk);
        // No cycle count assumed: only the watchdog ends a hung wait
        while (ack !== 1'b1)
        begin
            @(posedge clk);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
    begin
        wb(1'b1, a, d, 4'hf, q);
    end
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
    begin
        wb(1'b0, a, 32'h0, 4'hf, q);
        check(nm, q, exp);
    end
    endtask : rd

    // One reported data phase, with expectations worked out from the tables
    task automatic ev(input dpr_kind_e k, input logic up, input logic sec,
                      input logic pr, input logic sr);
        logic       pm;
        logic       sm;
        logic       ep;
        logic       es;
        logic [5:0] pl;
        logic [5:0] po;
        logic [5:0] sl;
        logic [5:0] so;
    begin
        pm = pr & up & !sec;
        sm = sr & !up & sec;
        ep = pr & ((!sec & ((k == DPR_READ) == up)) |
             (k == DPR_DWR & !up & sec & sr));
        es = sr & ((sec & ((k == DPR_READ) != up)) |
             (k == DPR_DWR & up & !sec & pr));
        wr(DPR_CTRL_OFS, {30'h0, sr, pr});
        wr(DPR_STAT_OFS, 32'h3);
        wr(DPR_IRQCL_OFS, 32'hf);
        dpr_bus_agent_inst.report(k, up, sec);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            #1;
            pl[i] = p_pin;
            po[i] = p_oe;
            sl[i] = s_pin;
            so[i] = s_oe;
        end
        check("prim pin", {26'h0, pl}, ep ? 32'h3d : 32'h3f);
        check("prim oe", {26'h0, po}, ep ? 32'h06 : 32'h0);
        check("sec pin", {26'h0, sl}, es ? 32'h3d : 32'h3f);
        check("sec oe", {26'h0, so}, es ? 32'h06 : 32'h0);
        rd("stat", DPR_STAT_OFS, {30'h0, sm, pm});
        rd("irq stat", DPR_IRQST_OFS, {28'h0, es, ep, sm, pm});
        check("irq", {31'h0, irq}, {31'h0, |({es, ep, sm, pm} & irq_en)});
    end
    endtask : ev

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        nrst = 1'b0;
        {adr, wdat, sel, we, cyc, stb} = '0;
        irq_en = 4'hf;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd("ctrl rst", DPR_CTRL_OFS, 32'h0);
        rd("irqen rst", DPR_IRQEN_OFS, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        begin : sel_off
            logic [31:0] q;
            wb(1'b1, DPR_CTRL_OFS, 32'h3, 4'h0, q);
        end
        rd("ctrl sel", DPR_CTRL_OFS, 32'h0);
        wr(DPR_IRQEN_OFS, 32'hf);
        rd("irqen", DPR_IRQEN_OFS, 32'hf);
        for (int e = 0; e < 4; e++)
            for (int k = 0; k < 3; k++)
                for (int u = 0; u < 2; u++)
                    for (int s = 0; s < 2; s++)
                        ev(dpr_kind_e'(k), u[0], s[0], e[0], e[1]);
        // Masked: status still sets, output must stay quiet
        irq_en = 4'h0;
        wr(DPR_IRQEN_OFS, 32'h0);
        ev(DPR_READ, 1'b1, 1'b0, 1'b1, 1'b1);
        complete_run();
    end
endmodule : test_bridge_data_parity_reporting
